// File: src/pit_pkg.sv
// Shared constants and types for the initiator transaction control ends
package pit_pkg;
  localparam int          PIT_DW          = 32;
  localparam int          PIT_BUF_DEPTH   = 16;
  localparam int          PIT_IDX_W       = 4;
  localparam int          PIT_LEN_W       = 5;
  localparam logic [3:0]  PIT_CMD_MEM_WR  = 4'h7;
  localparam logic [3:0]  PIT_CMD_MEM_RD  = 4'h6;
  localparam logic [3:0]  PIT_BE_ALL      = 4'h0;
  localparam logic [3:0]  PIT_DEVSEL_TMO  = 4'h5;
  // Register byte offsets
  localparam logic [7:0]  PIT_REG_CTRL    = 8'h00;
  localparam logic [7:0]  PIT_REG_CMD     = 8'h04;
  localparam logic [7:0]  PIT_REG_ADDR    = 8'h08;
  localparam logic [7:0]  PIT_REG_LEN     = 8'h0C;
  localparam logic [7:0]  PIT_REG_STATUS  = 8'h10;
  localparam logic [7:0]  PIT_REG_BUF     = 8'h40;
  // Field positions
  localparam int          PIT_CTRL_GO     = 0;
  localparam int          PIT_ST_BUSY     = 0;
  localparam int          PIT_ST_DONE     = 1;
  localparam int          PIT_ST_ABORT    = 2;
  // Reset values and AXI response codes
  localparam logic [3:0]  PIT_CMD_RST     = 4'h6;
  localparam logic [4:0]  PIT_LEN_RST     = 5'h01;
  localparam logic [1:0]  PIT_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PIT_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    D_IDLE, D_REQ, D_APH, D_ADDR, D_DATA, D_WAIT, D_LAST, D_TURN
  } pit_dev_state_t;

  typedef enum logic [1:0] {U_IDLE, U_SETUP, U_REQ, U_XFER} pit_usr_state_t;
endpackage

// File: src/pit_local_if.sv
// Local user-side link between the initiator core and the user application
`timescale 1ns/1ns
interface pit_local_if;
  logic [31:0] lad_usr_out;
  logic        lad_usr_oe;
  logic [31:0] lad_dev_out;
  logic        lad_dev_oe;
  logic [31:0] local_addr_data_bus;
  logic [3:0]  local_cmd_byte_enables;
  logic        local_write_direction;
  logic        request;
  logic        ready;
  logic        complete;
  logic        addr_phase_n;
  logic        init_idle;
  logic        data_state;
  logic        transfer_valid_strobe;
  logic        term_retry;
  logic        term_abort;

  // Shared internal bus resolved from the two drive enables
  assign local_addr_data_bus = lad_usr_oe ? lad_usr_out :
                               lad_dev_oe ? lad_dev_out : 32'h0;

  modport dev (
    input  local_addr_data_bus, local_cmd_byte_enables,
           local_write_direction, request, ready, complete,
    output lad_dev_out, lad_dev_oe, addr_phase_n, init_idle, data_state,
           transfer_valid_strobe, term_retry, term_abort
  );
  modport usr (
    input  local_addr_data_bus, addr_phase_n, init_idle, data_state,
           transfer_valid_strobe, term_retry, term_abort,
    output lad_usr_out, lad_usr_oe, local_cmd_byte_enables,
           local_write_direction, request, ready, complete
  );
endinterface

// File: src/pit_dev.sv
// Initiator core: local handshake to PCI bus master signalling
`timescale 1ns/1ns
module pit_dev
  import pit_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  pit_local_if.dev         lb,
  input  wire logic        master_enable_bit,
  output logic             req_n,
  input  wire logic        gnt_n,
  input  wire logic        frame_n_in,
  output logic             frame_n_out,
  output logic             frame_n_oe,
  input  wire logic        irdy_n_in,
  output logic             irdy_n_out,
  output logic             irdy_n_oe,
  input  wire logic        trdy_n,
  input  wire logic        stop_n,
  input  wire logic        devsel_n,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  output logic      [3:0]  cbe_n_out,
  output logic             cbe_n_oe
);
  pit_dev_state_t state;
  pit_dev_state_t next_state;
  logic           bus_idle;
  logic           strobe;
  logic           in_data;
  logic           drive_phase;
  logic           any_xfer;
  logic           nodev;
  logic [3:0]     devsel_cnt;
  logic           next_irdy_n;

  assign bus_idle    = frame_n_in && irdy_n_in;
  assign in_data     = state inside {D_DATA, D_WAIT, D_LAST};
  assign drive_phase = state inside {D_ADDR, D_DATA, D_WAIT, D_LAST};
  assign strobe      = in_data && !irdy_n_out && !trdy_n;
  assign nodev       = devsel_n && (devsel_cnt >= PIT_DEVSEL_TMO);

  assign lb.transfer_valid_strobe = strobe;
  assign lb.addr_phase_n = (state != D_APH);
  assign lb.init_idle    = state inside {D_IDLE, D_REQ, D_APH};
  assign lb.data_state   = in_data;

  always_comb begin
    next_state = state;
    unique case (state)
      D_IDLE: if (lb.request && master_enable_bit) next_state = D_REQ;
      D_REQ: begin
        if (!lb.request || !master_enable_bit) begin
          next_state = D_IDLE;
        end else if (!gnt_n && bus_idle) begin
          next_state = D_APH;
        end
      end
      D_APH:  next_state = D_ADDR;
      D_ADDR: next_state = lb.complete ? D_LAST : D_DATA;
      D_DATA: begin
        if (!stop_n || nodev) begin
          next_state = D_LAST;
        end else if (strobe && lb.complete) begin
          next_state = D_WAIT;
        end
      end
      D_WAIT: next_state = D_LAST;
      D_LAST: if (strobe || !stop_n || nodev) next_state = D_TURN;
      D_TURN: next_state = D_IDLE;
    endcase
  end

  // Writes drop IRDY one cycle after each transfer so new data can settle
  always_comb begin
    next_irdy_n = 1'b1;
    if ((next_state == D_DATA || next_state == D_LAST) && lb.ready &&
        !(strobe && lb.local_write_direction && next_state == D_DATA) &&
        !(state == D_LAST && next_state == D_LAST && nodev)) begin
      next_irdy_n = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state <= D_IDLE;
    else          state <= next_state;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_n <= 1'b1;
    end else begin
      req_n <= !(lb.request && master_enable_bit &&
                 state inside {D_IDLE, D_REQ});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_n_out <= 1'b1;
      frame_n_oe  <= 1'b0;
      irdy_n_out  <= 1'b1;
      irdy_n_oe   <= 1'b0;
      cbe_n_oe    <= 1'b0;
    end else begin
      frame_n_out <= !(next_state inside {D_ADDR, D_DATA, D_WAIT});
      frame_n_oe  <= next_state inside {D_ADDR, D_DATA, D_WAIT, D_LAST};
      irdy_n_out  <= next_irdy_n;
      irdy_n_oe   <= next_state inside {D_ADDR, D_DATA, D_WAIT, D_LAST,
                                        D_TURN};
      cbe_n_oe    <= next_state inside {D_ADDR, D_DATA, D_WAIT, D_LAST};
    end
  end

  // Address/command captured in the local address cycle appear one later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_out    <= 32'h0;
      cbe_n_out <= 4'hF;
      ad_oe     <= 1'b0;
    end else begin
      if (state == D_APH || (in_data && irdy_n_out) ||
          (state == D_ADDR)) begin
        ad_out <= lb.local_addr_data_bus;
      end
      cbe_n_out <= lb.local_cmd_byte_enables;
      ad_oe     <= (next_state == D_ADDR) ||
                   (lb.local_write_direction &&
                    next_state inside {D_DATA, D_WAIT, D_LAST});
    end
  end

  // Read words go onto the local bus the cycle after their strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lb.lad_dev_out <= 32'h0;
      lb.lad_dev_oe  <= 1'b0;
    end else begin
      lb.lad_dev_out <= ad_in;
      lb.lad_dev_oe  <= strobe && !lb.local_write_direction;
    end
  end

  // Termination reporting: retry before any data, abort on no target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      any_xfer      <= 1'b0;
      devsel_cnt    <= 4'h0;
      lb.term_retry <= 1'b0;
      lb.term_abort <= 1'b0;
    end else begin
      if (state == D_ADDR)  any_xfer <= 1'b0;
      else if (strobe)      any_xfer <= 1'b1;
      if (!drive_phase || !devsel_n) devsel_cnt <= 4'h0;
      else if (!nodev)               devsel_cnt <= devsel_cnt + 4'h1;
      // One pulse per ending, although the target holds its stop longer
      lb.term_retry <= in_data && !stop_n && trdy_n && !devsel_n &&
                       !any_xfer && !lb.term_retry;
      lb.term_abort <= (state == D_DATA || state == D_LAST) &&
                       (nodev || (!stop_n && devsel_n)) && !lb.term_abort;
    end
  end
endmodule

// File: src/pit_usr.sv
// User application: AXI4-Lite controlled initiator transaction sequencer
// Function
// - Present address and command before raising request.
// - Memory write uses command code 0111b.
// - Direction low read; from command bit 0.
// - Write data ready when transaction starts.
// - Core requests only with master enable set.
// - Hold request until address-phase indicator.
// - Core inserts IRDY wait before final burst transfer.
// - Ready high signals data available.
// - Core drives REQ low one clock after request.
// - Start needs grant, idle bus, address indicator.
// - PCI address phase one clock after indicator.
// - Address indicator overlaps idle by one clock.
// - Address enabled onto local bus during indicator.
// - FRAME low with earlier command and address.
// - Data-phase byte enables all zero.
// - Strobe when data state, IRDY, TRDY low.
// - Hold completion until data state ends.
// - Single transfer: completion with request.
// - Burst: completion at next-to-last transfer; a two-word write gets it only after its first transfer, so three transfers run.
// - Burst read: completion on second-to-last strobe.
// - Next-to-last: completion from delayed data state.
// - Last count: completion immediately with pending request.
// - Restart on retry; never after aborts.
`timescale 1ns/1ns
module pit_usr
  import pit_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  pit_local_if.usr         lb,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  pit_usr_state_t         state;
  logic [3:0]             cmd;
  logic [31:0]            start_addr;
  logic [PIT_LEN_W-1:0]   len;
  logic [PIT_LEN_W-1:0]   rem;
  logic [PIT_IDX_W-1:0]   idx;
  logic [31:0]            buffer [PIT_BUF_DEPTH];
  logic                   done_flag;
  logic                   abort_flag;
  logic                   retry_seen;
  logic                   cmpl_hold;
  logic                   data_state_delayed;
  logic                   strobe_d;
  logic                   go;
  logic                   wr_take;
  logic                   busy;
  logic                   finish;
  logic                   wr_phase;

  function automatic logic in_buf(input logic [7:0] a);
    return a[7:6] == PIT_REG_BUF[7:6];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return in_buf(a) || a inside {PIT_REG_CTRL, PIT_REG_CMD, PIT_REG_ADDR,
                                  PIT_REG_LEN, PIT_REG_STATUS};
  endfunction

  assign busy    = (state != U_IDLE);
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign go      = wr_take && s_axi_awaddr == PIT_REG_CTRL &&
                   s_axi_wstrb[0] && s_axi_wdata[PIT_CTRL_GO] && !busy;
  assign finish  = (state == U_XFER) && lb.init_idle && !lb.data_state;

  // AXI4-Lite write channel: address and data taken together
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PIT_RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(s_axi_awaddr) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd        <= PIT_CMD_RST;
      start_addr <= 32'h0;
      len        <= PIT_LEN_RST;
    end else if (wr_take && !busy) begin
      if (s_axi_awaddr == PIT_REG_CMD && s_axi_wstrb[0]) begin
        cmd <= s_axi_wdata[3:0];
      end
      if (s_axi_awaddr == PIT_REG_ADDR) begin
        start_addr <= s_axi_wdata;
      end
      if (s_axi_awaddr == PIT_REG_LEN && s_axi_wstrb[0] &&
          s_axi_wdata[PIT_LEN_W-1:0] != 5'h00 &&
          s_axi_wdata[PIT_LEN_W-1:0] <= 5'h10) begin
        len <= s_axi_wdata[PIT_LEN_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= PIT_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
      s_axi_rdata  <= 32'h0;
      if (in_buf(s_axi_araddr)) begin
        s_axi_rdata <= buffer[s_axi_araddr[5:2]];
      end else begin
        unique case (s_axi_araddr)
          PIT_REG_CMD:    s_axi_rdata <= {28'h0, cmd};
          PIT_REG_ADDR:   s_axi_rdata <= start_addr;
          PIT_REG_LEN:    s_axi_rdata <= {27'h0, len};
          PIT_REG_STATUS: s_axi_rdata <= {29'h0, abort_flag, done_flag,
                                          busy};
          default:        s_axi_rdata <= 32'h0;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Buffer: software fills write data, read words land after their strobe
  always_ff @(posedge aclk) begin
    if (strobe_d && !lb.local_write_direction) begin
      buffer[idx - 4'h1] <= lb.local_addr_data_bus;
    end else if (wr_take && in_buf(s_axi_awaddr) && !busy) begin
      buffer[s_axi_awaddr[5:2]] <= s_axi_wdata;
    end
  end

  // Transaction sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= U_IDLE;
    end else begin
      unique case (state)
        U_IDLE:  if (go) state <= U_SETUP;
        U_SETUP: state <= U_REQ;
        U_REQ:   if (!lb.addr_phase_n) state <= U_XFER;
        U_XFER: begin
          if (finish) begin
            state <= retry_seen ? U_SETUP : U_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag  <= 1'b0;
      abort_flag <= 1'b0;
      retry_seen <= 1'b0;
    end else begin
      if (lb.term_retry) retry_seen <= 1'b1;
      else if (state == U_SETUP) retry_seen <= 1'b0;
      if (finish && !retry_seen) done_flag <= 1'b1;
      else if (go) done_flag <= 1'b0;
      if (lb.term_abort) abort_flag <= 1'b1;
      else if (go) abort_flag <= 1'b0;
    end
  end

  // Transfer counter restarts from the full length on every attempt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem <= PIT_LEN_RST;
      idx <= 4'h0;
    end else if (state == U_SETUP) begin
      rem <= len;
      idx <= 4'h0;
    end else if (lb.transfer_valid_strobe) begin
      rem <= rem - 5'h01;
      idx <= idx + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_state_delayed     <= 1'b0;
      strobe_d               <= 1'b0;
      lb.local_write_direction <= 1'b0;
    end else begin
      data_state_delayed <= lb.data_state;
      strobe_d           <= lb.transfer_valid_strobe;
      if (!lb.data_state) lb.local_write_direction <= cmd[0];
    end
  end

  always_comb begin
    lb.complete = cmpl_hold ||
                  (state == U_REQ && rem == 5'h01) ||
                  (state == U_XFER && rem == 5'h01) ||
                  (rem == 5'h02 && data_state_delayed) ||
                  (!lb.local_write_direction && rem == 5'h02 &&
                   lb.transfer_valid_strobe && lb.data_state);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpl_hold <= 1'b0;
    end else begin
      cmpl_hold <= lb.complete && !finish && state != U_IDLE &&
                   state != U_SETUP;
    end
  end

  assign lb.request = (state == U_REQ);
  assign lb.ready   = (state == U_REQ) || (state == U_XFER);
  assign lb.local_cmd_byte_enables = lb.data_state ? PIT_BE_ALL : cmd;
  // Write words stand from the bus address cycle, when the core takes word 0
  assign wr_phase = lb.local_write_direction && state == U_XFER &&
                    !lb.init_idle;
  assign lb.lad_usr_oe  = !lb.addr_phase_n || state == U_SETUP ||
                          wr_phase;
  assign lb.lad_usr_out = wr_phase ? buffer[idx] : start_addr;
endmodule

// File: dv/pit_assertions.sv
// Concurrent checks on the local link and the bus pins of the core
`timescale 1ns/1ns
module pit_assertions
  import pit_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        master_enable_bit,
  input wire logic        req_n,
  input wire logic        gnt_n,
  input wire logic        frame_n_in,
  input wire logic        irdy_n_in,
  input wire logic        frame_n_out,
  input wire logic        frame_n_oe,
  input wire logic        irdy_n_out,
  input wire logic        trdy_n,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic [3:0]  cbe_n_out,
  input wire logic        cbe_n_oe,
  input wire logic [31:0] local_addr_data_bus,
  input wire logic [3:0]  local_cmd_byte_enables,
  input wire logic        local_write_direction,
  input wire logic        request,
  input wire logic        complete,
  input wire logic        addr_phase_n,
  input wire logic        init_idle,
  input wire logic        data_state,
  input wire logic        transfer_valid_strobe,
  input wire logic        lad_usr_oe,
  input wire logic        lad_dev_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence bus_addr_s;
    !frame_n_out && frame_n_oe && ad_oe && cbe_n_oe;
  endsequence
  sequence idle_overlap_s;
    init_idle ##1 (!init_idle && addr_phase_n);
  endsequence
  sequence final_phase_s;
    irdy_n_out ##1 (!irdy_n_out && frame_n_out);
  endsequence

  req_gate_a: assert property (
    req_n && !master_enable_bit && !$past(master_enable_bit) |=> req_n)
    else $error("bus requested while mastering disabled");
  req_delay_a: assert property (
    $rose(request) && master_enable_bit && req_n |=> !req_n)
    else $error("bus request not one clock after request");
  start_cond_a: assert property (
    $fell(addr_phase_n) |->
      !$past(gnt_n) && $past(frame_n_in) && $past(irdy_n_in))
    else $error("address indicator without grant and idle bus");
  addr_fwd_a: assert property (
    !addr_phase_n |=> bus_addr_s ##0
      (ad_out == $past(local_addr_data_bus)
       && cbe_n_out == $past(local_cmd_byte_enables)))
    else $error("bus address phase wrong after indicator");
  idle_overlap_a: assert property (
    !addr_phase_n |-> idle_overlap_s)
    else $error("indicator and idle overlap not one clock");
  strobe_def_a: assert property (
    transfer_valid_strobe == (data_state && !irdy_n_out && !trdy_n))
    else $error("transfer strobe mismatch");
  burst_wait_a: assert property (
    transfer_valid_strobe && complete && !frame_n_out |=> final_phase_s)
    else $error("no wait state before final burst transfer");
  req_hold_a: assert property (
    $fell(request) |-> !$past(addr_phase_n))
    else $error("request dropped before address indicator");
  data_be_a: assert property (
    data_state |-> local_cmd_byte_enables == PIT_BE_ALL)
    else $error("byte enables not all zero in data phase");
  comp_hold_a: assert property (
    complete && data_state |=> complete || !data_state)
    else $error("completion dropped inside data state");
  setup_a: assert property (
    $rose(request) |->
      $past(lad_usr_oe) &&
      local_write_direction == local_cmd_byte_enables[0])
    else $error("request raised before setup");
  lad_drive_a: assert property (
    !addr_phase_n |-> lad_usr_oe && !lad_dev_oe)
    else $error("address not driven during indicator");
endmodule

// File: dv/pci_initiator_transaction_control_tb.sv
// Bench joining both ends, with an arbiter and a target on the bus pins
`timescale 1ns/1ns
module pci_initiator_transaction_control_tb
  import pit_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        master_enable_bit = 1'b1;
  logic        gnt_n = 1'b1;
  logic        req_n, frame_n_out, frame_n_oe, irdy_n_out, irdy_n_oe;
  logic        ad_oe, cbe_n_oe, frame_n_in, irdy_n_in, strobe;
  logic        trdy_n, stop_n, devsel_n;
  logic [31:0] ad_out, ad_in, s_axi_rdata, cap_addr, d;
  logic [3:0]  cbe_n_out, cap_cmd;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic        frame_q = 1'b1, in_txn = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [4:0]  beat = 5'h00;
  logic [31:0] wmem [16];
  logic [7:0]  rst_a [4] = '{PIT_REG_CMD, PIT_REG_ADDR, PIT_REG_LEN,
                             PIT_REG_STATUS};
  logic [31:0] rst_v [4] = '{{28'h0, PIT_CMD_RST}, 32'h0,
                             {27'h0, PIT_LEN_RST}, 32'h0};
  logic [3:0]  c_cmd [6] = '{4'h6, 4'h6, 4'h7, 4'h7, 4'h6, 4'h7};
  logic [4:0]  c_len [6] = '{5'h04, 5'h10, 5'h01, 5'h03, 5'h02, 5'h02};
  logic [1:0]  c_md [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  int          errors = 0, comparisons = 0, retries = 0;

  pit_local_if lb ();
  pit_dev u_pit_dev (.aclk, .aresetn, .lb(lb), .master_enable_bit, .req_n,
    .gnt_n, .frame_n_in, .frame_n_out, .frame_n_oe, .irdy_n_in, .irdy_n_out,
    .irdy_n_oe, .trdy_n, .stop_n, .devsel_n, .ad_in, .ad_out, .ad_oe,
    .cbe_n_out, .cbe_n_oe);
  pit_usr u_pit_usr (.aclk, .aresetn, .lb(lb), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pit_assertions u_pit_assertions (.aclk, .aresetn, .master_enable_bit,
    .req_n, .gnt_n, .frame_n_in, .irdy_n_in, .frame_n_out, .frame_n_oe,
    .irdy_n_out, .trdy_n, .ad_out, .ad_oe, .cbe_n_out, .cbe_n_oe,
    .local_addr_data_bus(lb.local_addr_data_bus),
    .local_cmd_byte_enables(lb.local_cmd_byte_enables),
    .local_write_direction(lb.local_write_direction),
    .request(lb.request), .complete(lb.complete),
    .addr_phase_n(lb.addr_phase_n), .init_idle(lb.init_idle),
    .data_state(lb.data_state), .lad_usr_oe(lb.lad_usr_oe),
    .transfer_valid_strobe(lb.transfer_valid_strobe),
    .lad_dev_oe(lb.lad_dev_oe));

  // Bus lines with pull-ups; a released AD bus shows the inverse value
  assign frame_n_in = frame_n_oe ? frame_n_out : 1'b1;
  assign irdy_n_in  = irdy_n_oe ? irdy_n_out : 1'b1;
  assign trdy_n     = !(in_txn && mode == 2'h0);
  assign stop_n     = !(in_txn && mode == 2'h1);
  assign devsel_n   = !(in_txn && mode != 2'h2);
  assign strobe     = in_txn && !irdy_n_in && !trdy_n;
  assign ad_in = ad_oe ? ad_out : in_txn ? {16'hC0DE, 11'h000, beat} : ~ad_out;

  // Arbiter grants one clock after the request; target claims each transaction except in mode 2, where it never claims
  always @(posedge aclk) begin
    frame_q <= frame_n_in;
    gnt_n   <= req_n;
    if (!frame_n_in && frame_q) begin
      cap_addr <= ad_in;
      cap_cmd  <= cbe_n_out;
      beat     <= 5'h00;
      in_txn   <= 1'b1;
    end else if ((strobe && frame_n_in) || lb.term_retry || lb.term_abort) begin
      in_txn <= 1'b0;
    end
    if (strobe) begin
      beat <= beat + 5'h01;
      if (ad_oe) begin
        wmem[beat[3:0]] <= ad_out;
      end
    end
    if (lb.term_retry) begin
      mode    <= 2'h0;
      retries <= retries + 1;
    end
  end

  initial begin
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] taddr(logic [3:0] c, logic [4:0] l);
    return {18'h10000, c, l, 5'h00};
  endfunction
  function automatic logic [31:0] wpat(logic [4:0] l, int i);
    return {16'h5A5A, 3'h0, l, 4'h0, 4'(i)};
  endfunction

  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail_wait;
    errors++;
    conclude();
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) fail_wait();
    last_resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) fail_wait();
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask

  task automatic start(input logic [3:0] c, input logic [4:0] l);
    for (int i = 0; i < l; i++) wr(PIT_REG_BUF + 8'(4 * i), wpat(l, i));
    wr(PIT_REG_ADDR, taddr(c, l));
    wr(PIT_REG_LEN, {27'h0, l});
    wr(PIT_REG_CMD, {28'h0, c});
    wr(PIT_REG_CTRL, 32'h1);
  endtask

  task automatic finish(input logic [3:0] c, input logic [4:0] l,
                        input logic [1:0] md);
    int n;
    for (n = 0; n < 200; n++) begin
      rd(PIT_REG_STATUS, d);
      if (d[PIT_ST_BUSY] === 1'b0) break;
    end
    if (n == 200) fail_wait();
    check("abort flag", d[PIT_ST_ABORT], md == 2'h2);
    if (md == 2'h2) begin
      repeat (20) @(posedge aclk);
      check("request after abort", req_n, 1'b1);
    end else begin
      check("done flag", d[PIT_ST_DONE], 1'b1);
      check("bus command", cap_cmd, c);
      check("bus address", cap_addr, taddr(c, l));
      check("transfer count", beat, l);
      for (int i = 0; i < l; i++) begin
        if (c == PIT_CMD_MEM_WR) begin
          check("written word", wmem[i], wpat(l, i));
        end else begin
          rd(PIT_REG_BUF + 8'(4 * i), d);
          check("read word", d, {16'hC0DE, 11'h000, 5'(i)});
        end
      end
    end
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rst_a[i]) begin
      rd(rst_a[i], d);
      check("reset value", d, rst_v[i]);
    end
    wr(8'h20, 32'h1);
    check("unmapped write response", last_resp, PIT_RESP_SLVERR);
    rd(8'h20, d);
    check("unmapped read response", last_resp, PIT_RESP_SLVERR);
    wr(PIT_REG_LEN, 32'h11);
    rd(PIT_REG_LEN, d);
    check("length kept", d, {27'h0, PIT_LEN_RST});
    master_enable_bit <= 1'b0;
    start(PIT_CMD_MEM_RD, 5'h01);
    repeat (20) @(posedge aclk);
    check("request while disabled", req_n, 1'b1);
    wr(PIT_REG_ADDR, 32'h0);
    rd(PIT_REG_ADDR, d);
    check("address while busy", d, taddr(PIT_CMD_MEM_RD, 5'h01));
    master_enable_bit <= 1'b1;
    finish(PIT_CMD_MEM_RD, 5'h01, 2'h0);
    foreach (c_cmd[k]) begin
      mode <= c_md[k];
      start(c_cmd[k], c_len[k]);
      finish(c_cmd[k], c_len[k], c_md[k]);
    end
    check("retry count", retries, 32'h1);
    conclude();
  end
endmodule
